/* hw/adcss_pkg.sv */
// shared constants for the scan sequencer link and its host controller
package adcss_pkg;
    // ==========================================================
    // device register addresses on the serial link
    localparam logic [3:0] ADDR_RESULT = 4'h0; // conversion_result, read only
    localparam logic [3:0] ADDR_CONFIG = 4'h1; // converter state, auto-zero
    localparam logic [3:0] ADDR_MODE   = 4'h3; // conversion mode, output format
    localparam logic [3:0] ADDR_INSEL  = 4'h6; // input_select
    localparam logic [3:0] ADDR_SCAN   = 4'h7; // channel_scan_setup
    localparam logic [3:0] ADDR_TIMER  = 4'h8; // inter-cycle interval
    localparam logic [3:0] ADDR_OFSCAL = 4'h9; // offset_correction
    // ==========================================================
    // field positions
    localparam int CFG_STATE_LSB = 0;  // converter state select [1:0]
    localparam int CFG_AZ_BIT    = 2;  // auto_zero_input_swap_en
    localparam int MODE_CONV_LSB = 0;  // conversion_mode_select [1:0]
    localparam int MODE_FMT_LSB  = 2;  // output format select [1:0]
    localparam int SCAN_DLY_LSB  = 20; // intra_cycle_delay [2:0]
    localparam int HDR_RD_BIT    = 7;  // frame header: 1 = read
    localparam int HDR_ADDR_LSB  = 3;  // frame header: address [3:0]
    localparam int FRAME_BITS    = 32; // header byte plus 24 data bits
    localparam int HDR_BITS      = 8;
    // ==========================================================
    // reset values and codes
    localparam logic [7:0]  INSEL_RST = 8'h01;
    localparam logic [23:0] REG_RST   = 24'h000000;
    localparam logic [1:0]  STATE_RUN = 2'h3; // converting
    localparam logic [1:0]  STATE_STB = 2'h2; // standby
    localparam logic [1:0]  STATE_OFF = 2'h0; // converter shutdown
    localparam logic [1:0]  MODE_CONT = 2'h3; // repeating
    localparam logic [1:0]  FMT_TAG   = 2'h3; // channel tag in result
    localparam logic [1:0]  GAIN_PROG = 2'h0; // programmed gain applies
    localparam logic [1:0]  GAIN_1X   = 2'h1;
    localparam logic [1:0]  GAIN_033X = 2'h2;
    // ==========================================================
    // forced multiplexer codes of the differential pair and internal resource channels
    localparam logic [7:0] MUX_OFFSET = 8'h88;
    localparam logic [7:0] MUX_VCM    = 8'hF8;
    localparam logic [7:0] MUX_AVDD   = 8'h98;
    localparam logic [7:0] MUX_TEMP   = 8'hDE;
    localparam logic [7:0] MUX_PAIR_D = 8'h67;
    localparam logic [7:0] MUX_PAIR_C = 8'h45;
    localparam logic [7:0] MUX_PAIR_B = 8'h23;
    localparam logic [7:0] MUX_PAIR_A = 8'h01;
    localparam logic [3:0] MUX_SE_LO  = 4'h8; // low nibble of single-ended code
    localparam logic [23:0] DLY_BASE  = 24'h000008; // modulator periods, code 001
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCK_HALF_NS   = 250; // least half period of the link clock
    localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========================================================
    // host controller register offsets (APB byte addresses)
    localparam logic [7:0] HOST_CMD   = 8'h00;
    localparam logic [7:0] HOST_STAT  = 8'h04;
    localparam logic [7:0] HOST_RDATA = 8'h08;
    localparam int CMD_RD_BIT    = 31;
    localparam int CMD_ADDR_LSB  = 24;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DRDY_BIT = 1;
endpackage

/* hw/adcss_link_if.sv */
// serial link between the scan sequencer and its host controller
`timescale 1ns/1ps
`default_nettype none
interface adcss_link_if;
    logic sck;  // link clock, made by the host, idle low
    logic cs_n; // frame select, active low
    logic mosi; // host to device data
    logic miso; // device to host data
    logic drdy; // data ready level, high until result read
    modport dev  (input sck, cs_n, mosi, output miso, drdy);
    modport host (output sck, cs_n, mosi, input miso, drdy);
endinterface
`default_nettype wire

/* hw/adcss_dev.sv */
// scan sequencer device end: serial register slave and conversion sequencer
//
// Contract
// - scan conversions are one-shot except in mode 11
// - conversion lasts one or two conversion times
// - modes 00/01/10 run one cycle, then stop
// - mode 11 repeats cycles with interval between
// - mode writes never reset running conversion
// - host changes mode just after data ready
// - scanning ignores input_select register
// - each finished conversion: data ready, result update
// - host reads result before next overwrite
// - nonzero mask scans, zero mask single-input
// - scan starts when host writes state 11
// - state stays 11 until scan ends
// - enabled channels only, bit 15 first
// - format 11 puts tag in top bits
// - tag is bit index; fixed mux codes
// - forced gain for supply, temp, common-mode
// - absent channel mask bits ignore writes
// - offset channel shorts input; host corrects
// - intra-cycle delay from scan bits 22:20
// - delay 0 or 8 shl (code-1) periods
// - 24-bit interval counter between cycles
// - delay holds standby, state reads 11
`timescale 1ns/1ps
`default_nettype none
module adcss_dev
    import adcss_pkg::*;
#(
    parameter logic [7:0]  MCLK_DIV  = 8'h04,     // clk cycles per modulator period
    parameter logic [22:0] CONV_MCLK = 23'h000040, // conversion_time, modulator periods
    parameter logic [15:0] IMPL_MASK = 16'hFFFF   // channels present in this variant
) (
    input  wire logic        clk,         // system clock
    input  wire logic        rst,         // synchronous reset, high
    adcss_link_if.dev        link,        // serial link to the host
    input  wire logic [15:0] conv_sample, // converted value from the filter
    output logic      [7:0]  mux_code,    // multiplexer code in force
    output logic      [1:0]  gain_sel,    // gain override code
    output logic             conv_active  // converter running a conversion
);
    typedef enum logic [1:0] {SQ_IDLE, SQ_CONV, SQ_DLY, SQ_TIMER} adcss_seq_type;

    typedef struct packed {
        logic [2:0]    sck_s;  // link clock synchroniser
        logic [2:0]    cs_s;   // select synchroniser
        logic [2:0]    mosi_s; // data synchroniser
        logic          sck_l;  // filtered link clock level
        logic          cs_l;   // filtered select level
        logic [5:0]    bits;   // bits taken in this frame
        logic [31:0]   rx;     // incoming frame
        logic [23:0]   tx;     // outgoing read data
        logic [1:0]    state;  // converter state select
        logic          az;     // auto_zero_input_swap_en
        logic [1:0]    mode;   // conversion_mode_select
        logic [1:0]    fmt;    // output format select
        logic [7:0]    insel;  // input_select
        logic [23:0]   scan;   // channel_scan_setup
        logic [23:0]   timer;  // inter-cycle interval
        logic [23:0]   ofscal; // offset_correction, kept for the host
        logic [23:0]   result; // conversion_result
        logic          drdy;   // data ready level
        adcss_seq_type seq;    // sequencer state
        logic [3:0]    ch;     // scanned channel
        logic [23:0]   cnt;    // modulator period countdown
        logic [7:0]    div;    // modulator divider
        logic [7:0]    code;   // multiplexer code out
        logic [1:0]    gain;   // gain override out
    } adcss_dev_type;

    adcss_dev_type q; // registered state
    adcss_dev_type n; // next state

    localparam logic [23:0] SCAN_WMASK = {4'h7, 4'h0, IMPL_MASK};

    // highest enabled channel strictly below lim; bit 4 flags a find
    function automatic logic [4:0] next_ch(input logic [15:0] m, input logic [4:0] lim);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (m[i] && (5'(i) < lim)) begin
                r = {1'b1, 4'(i)}; // later hit is higher priority
            end
        end
        return r;
    endfunction

    // multiplexer code forced for a scanned channel
    function automatic logic [7:0] ch_code(input logic [3:0] c);
        case (c)
            4'hF:    ch_code = MUX_OFFSET; // input shorted to ground
            4'hE:    ch_code = MUX_VCM;
            4'hD:    ch_code = MUX_AVDD;
            4'hC:    ch_code = MUX_TEMP;
            4'hB:    ch_code = MUX_PAIR_D;
            4'hA:    ch_code = MUX_PAIR_C;
            4'h9:    ch_code = MUX_PAIR_B;
            4'h8:    ch_code = MUX_PAIR_A;
            default: ch_code = {c, MUX_SE_LO}; // single-ended k*16+8
        endcase
    endfunction

    // gain forced for the supply, temperature and common-mode channels
    function automatic logic [1:0] ch_gain(input logic [3:0] c);
        case (c)
            4'hD:      ch_gain = GAIN_033X;
            4'hE, 4'hC: ch_gain = GAIN_1X;
            default:   ch_gain = GAIN_PROG;
        endcase
    endfunction

    // settling delay in modulator periods
    function automatic logic [23:0] dly_len(input logic [2:0] d);
        dly_len = (d == 3'h0) ? 24'h000000 : (DLY_BASE << (d - 3'h1));
    endfunction

    logic        scanning;  // any mask bit set
    logic [23:0] conv_len;  // length of one conversion
    logic        sck_new;   // agreed link clock level
    logic        cs_new;    // agreed select level
    logic        rise;      // link clock rising
    logic        fall;      // link clock falling
    logic        wr_done;   // frame complete, write decoded
    logic [3:0]  addr;      // frame address
    logic [23:0] wdat;      // frame write data
    logic [4:0]  nxt;       // next channel search result
    logic [4:0]  first;     // first channel of a cycle
    logic [23:0] rdat;      // read data mux

    // ==========================================================
    // next-state logic
    always_comb begin
        n = q;
        scanning = |q.scan[15:0];
        conv_len = q.az ? {CONV_MCLK, 1'b0} : {1'b0, CONV_MCLK};
        nxt      = next_ch(q.scan[15:0], {1'b0, q.ch});
        first    = next_ch(q.scan[15:0], 5'h10);
        // synchronisers: a change counts when stages two and three agree
        n.sck_s  = {q.sck_s[1:0], link.sck};
        n.cs_s   = {q.cs_s[1:0], link.cs_n};
        n.mosi_s = {q.mosi_s[1:0], link.mosi};
        sck_new  = (q.sck_s[1] == q.sck_s[2]) ? q.sck_s[2] : q.sck_l;
        cs_new   = (q.cs_s[1] == q.cs_s[2]) ? q.cs_s[2] : q.cs_l;
        n.sck_l  = sck_new;
        n.cs_l   = cs_new;
        rise     = !cs_new && sck_new && !q.sck_l;
        fall     = !cs_new && !sck_new && q.sck_l;
        addr     = q.rx[HDR_ADDR_LSB - 1 +: 4]; // last header bit not yet shifted in
        wdat     = {q.rx[22:0], q.mosi_s[2]};
        wr_done  = 1'b0;
        case (addr)
            ADDR_RESULT: rdat = q.result;
            ADDR_CONFIG: rdat = 24'({q.az, q.state});
            ADDR_MODE:   rdat = 24'({q.fmt, q.mode});
            ADDR_INSEL:  rdat = {16'h0000, q.insel};
            ADDR_SCAN:   rdat = q.scan;
            ADDR_TIMER:  rdat = q.timer;
            ADDR_OFSCAL: rdat = q.ofscal;
            default:     rdat = 24'h000000; // unmapped reads zero
        endcase
        // ======================================================
        // serial slave: sample on rise, shift out on fall
        if (cs_new) begin
            n.bits = 6'h00; // frame over, realign
        end else if (rise) begin
            n.rx   = {q.rx[30:0], q.mosi_s[2]};
            n.bits = q.bits + 6'h01;
            if (q.bits == 6'(HDR_BITS - 1)) begin
                n.tx = rdat; // header done, load read data
                if (q.mosi_s[2] == 1'b0 && q.rx[HDR_RD_BIT - 1] && addr == ADDR_RESULT) begin
                    n.drdy = 1'b0; // result fetched, drop data ready
                end
            end
            if (q.bits == 6'(FRAME_BITS - 1) && !q.rx[HDR_RD_BIT + 24 - 1]) begin
                wr_done = 1'b1;
            end
        end else if (fall && q.bits > 6'(HDR_BITS)) begin
            n.tx = {q.tx[22:0], 1'b0};
        end
        // ======================================================
        // register writes; the address sits 24 bits up by now
        addr = q.rx[HDR_ADDR_LSB + 23 +: 4];
        if (wr_done) begin
            case (addr)
                ADDR_MODE: begin
                    n.mode = wdat[MODE_CONV_LSB +: 2]; // no restart
                    n.fmt  = wdat[MODE_FMT_LSB +: 2];
                end
                ADDR_INSEL:  n.insel  = wdat[7:0];
                ADDR_SCAN:   n.scan   = wdat & SCAN_WMASK;
                ADDR_TIMER:  n.timer  = wdat;
                ADDR_OFSCAL: n.ofscal = wdat;
                ADDR_CONFIG: begin
                    n.az    = wdat[CFG_AZ_BIT];
                    n.state = wdat[CFG_STATE_LSB +: 2];
                    n.seq   = SQ_IDLE; // other states abort
                    if (wdat[CFG_STATE_LSB +: 2] == STATE_RUN) begin
                        n.seq  = SQ_CONV;
                        n.cnt  = wdat[CFG_AZ_BIT] ? {CONV_MCLK, 1'b0} : {1'b0, CONV_MCLK};
                        n.ch   = first[3:0];
                        n.code = scanning ? ch_code(first[3:0]) : q.insel;
                        n.gain = scanning ? ch_gain(first[3:0]) : GAIN_PROG;
                    end
                end
                default: ; // read-only or unmapped: ignored
            endcase
        end
        // ======================================================
        // modulator clock enable
        n.div = (q.div == MCLK_DIV - 8'h01) ? 8'h00 : q.div + 8'h01;
        // ======================================================
        // sequencer, advances once per modulator period, skipping any period that ends as a write completes
        if (q.div == MCLK_DIV - 8'h01 && !wr_done) begin
            case (q.seq)
                SQ_CONV: begin
                    if (q.cnt > 24'h000001) begin
                        n.cnt = q.cnt - 24'h000001;
                    end else begin
                        n.drdy   = 1'b1;
                        n.result = (q.fmt == FMT_TAG && scanning) ?
                                   {q.ch, 4'h0, conv_sample} :
                                   {8'h00, conv_sample};
                        n.cnt    = conv_len;
                        if (scanning && nxt[4]) begin
                            n.ch   = nxt[3:0];
                            n.code = ch_code(nxt[3:0]); // switch at delay start
                            n.gain = ch_gain(nxt[3:0]);
                            n.cnt  = dly_len(q.scan[SCAN_DLY_LSB +: 3]);
                            n.seq  = (n.cnt == 24'h000000) ? SQ_CONV : SQ_DLY;
                            if (n.cnt == 24'h000000) begin
                                n.cnt = conv_len;
                            end
                        end else if (q.mode == MODE_CONT) begin
                            n.ch   = first[3:0];
                            n.code = scanning ? ch_code(first[3:0]) : q.insel;
                            n.gain = scanning ? ch_gain(first[3:0]) : GAIN_PROG;
                            n.seq  = (scanning && q.timer != 24'h000000) ? SQ_TIMER
                                                                         : SQ_CONV;
                            if (scanning && q.timer != 24'h000000) begin
                                n.cnt = q.timer;
                            end
                        end else begin
                            n.seq   = SQ_IDLE;
                            n.state = q.mode[1] ? STATE_STB : STATE_OFF;
                        end
                    end
                end
                SQ_DLY, SQ_TIMER: begin // converter idle, state still reads 11
                    if (q.cnt > 24'h000001) begin
                        n.cnt = q.cnt - 24'h000001;
                    end else begin
                        n.seq = SQ_CONV;
                        n.cnt = conv_len;
                    end
                end
                default: ; // idle waits for a start write
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            q       <= '0;
            q.sck_l <= 1'b0;
            q.cs_l  <= 1'b1;          // frame select idles high
            q.cs_s  <= 3'h7;
            q.insel <= INSEL_RST;
            q.scan  <= REG_RST;       // single-input mode at start
            q.seq   <= SQ_IDLE;
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // outputs
    assign link.miso   = q.tx[23];
    assign link.drdy   = q.drdy;
    assign mux_code    = q.code;
    assign gain_sel    = q.gain;
    assign conv_active = (q.seq == SQ_CONV);
endmodule
`default_nettype wire

/* hw/adcss_host.sv */
// host end: APB-programmed serial controller that drives the link
`timescale 1ns/1ps
`default_nettype none
module adcss_host
    import adcss_pkg::*;
#(
    parameter int SCK_HALF = SCK_HALF_CYC // clk cycles per link clock half period
) (
    input  wire logic        clk,     // system clock
    input  wire logic        rst,     // synchronous reset, high
    input  wire logic        psel,    // APB select
    input  wire logic        penable, // APB access phase
    input  wire logic        pwrite,  // APB direction
    input  wire logic [7:0]  paddr,   // APB byte address
    input  wire logic [31:0] pwdata,  // APB write data
    output logic      [31:0] prdata,  // APB read data
    output logic             pready,  // APB ready, always high
    output logic             pslverr, // APB error on unmapped address
    adcss_link_if.host       link     // serial link to the device
);
    typedef struct packed {
        logic [7:0]  div;    // half-period counter
        logic        sck;    // link clock out
        logic        cs_n;   // frame select out
        logic        busy;   // frame running
        logic        gap;    // select high time after a frame
        logic [5:0]  bits;   // bits clocked
        logic [31:0] tx;     // outgoing frame
        logic [31:0] rx;     // incoming bits
        logic [23:0] rdata;  // last read data
        logic [2:0]  miso_s; // miso synchroniser
        logic [2:0]  drdy_s; // data ready synchroniser
        logic        drdy_l; // agreed data ready level
        logic [31:0] prd;    // registered APB read data
    } adcss_host_type;

    adcss_host_type q; // registered state
    adcss_host_type n; // next state

    localparam logic [7:0] HALF_END = 8'(SCK_HALF - 1);

    logic start; // accepted command write
    logic mapped; // address decodes

    // ==========================================================
    // next-state logic
    always_comb begin
        n        = q;
        n.miso_s = {q.miso_s[1:0], link.miso};
        n.drdy_s = {q.drdy_s[1:0], link.drdy};
        n.drdy_l = (q.drdy_s[1] == q.drdy_s[2]) ? q.drdy_s[2] : q.drdy_l;
        mapped   = (paddr == HOST_CMD) || (paddr == HOST_STAT) || (paddr == HOST_RDATA);
        // a command while a frame or its trailing select gap runs is dropped
        start = psel && penable && pwrite && paddr == HOST_CMD && !q.busy && !q.gap;
        // read data captured in the setup cycle
        if (psel && !penable) begin
            case (paddr)
                HOST_STAT:  n.prd = 32'({q.drdy_l, q.busy || q.gap});
                HOST_RDATA: n.prd = {8'h00, q.rdata};
                default:    n.prd = 32'h00000000;
            endcase
        end
        if (start) begin
            n.tx   = {pwdata[CMD_RD_BIT], pwdata[CMD_ADDR_LSB +: 4], 3'h0, pwdata[23:0]};
            n.cs_n = 1'b0;
            n.busy = 1'b1;
            n.div  = 8'h00;
            n.bits = 6'h00;
        end else if (q.busy) begin
            n.div = q.div + 8'h01;
            if (q.div == HALF_END) begin
                n.div = 8'h00;
                n.sck = !q.sck;
                if (q.sck) begin // falling edge: take miso, move mosi on
                    n.rx   = {q.rx[30:0], q.miso_s[2]};
                    n.tx   = {q.tx[30:0], 1'b0};
                    n.bits = q.bits + 6'h01;
                    if (q.bits == 6'(FRAME_BITS - 1)) begin
                        n.busy  = 1'b0;
                        n.cs_n  = 1'b1;
                        n.gap   = 1'b1;
                        n.rdata = {q.rx[22:0], q.miso_s[2]};
                    end
                end
            end
        end else if (q.gap) begin
            n.div = q.div + 8'h01;
            if (q.div == HALF_END) begin
                n.div = 8'h00;
                n.gap = 1'b0;
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            q      <= '0;
            q.cs_n <= 1'b1; // idle: no frame
        end else begin
            q <= n;
        end
    end

    // ==========================================================
    // outputs
    assign link.sck  = q.sck;
    assign link.cs_n = q.cs_n;
    assign link.mosi = q.tx[31];
    assign prdata    = q.prd;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped;
endmodule
`default_nettype wire

/* verif/adcss_sva.sv */
// checker: link framing, forced gains and conversion timing
`timescale 1ns/1ps
`default_nettype none
module adcss_sva import adcss_pkg::*; #(parameter int CONV_CLK = 512) (
    input wire logic       clk,        // clock
    input wire logic       rst,        // reset
    input wire logic       sck,        // link clock
    input wire logic       cs_n,       // frame select
    input wire logic       drdy,       // data ready
    input wire logic [7:0] mux_code,   // mux in force
    input wire logic [1:0] gain_sel,   // gain override
    input wire logic       conv_active // converting
);
    // ==========
    // length of the running conversion, cleared whenever conv_active is low
    logic [11:0] run_q; // clk cycles so far
    always_ff @(posedge clk) run_q <= (rst || !conv_active) ? 12'h000 : run_q + 12'h001;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_sck_framed: assert property (sck |-> !cs_n) else $error("sck outside frame");
    chk_frame_whole: assert property ($fell(cs_n) |=> !cs_n [*8]) else $error("short frame");
    chk_frame_gap: assert property ($rose(cs_n) |-> cs_n [*5]) else $error("short gap");
    chk_gain_supply: assert property (conv_active && mux_code == MUX_AVDD |->
        gain_sel == GAIN_033X) else $error("supply gain wrong");
    chk_gain_temp: assert property (conv_active && mux_code == MUX_TEMP |->
        gain_sel == GAIN_1X) else $error("temp gain wrong");
    chk_gain_cm: assert property (conv_active && mux_code == MUX_VCM |->
        gain_sel == GAIN_1X) else $error("common mode gain wrong");
    chk_drdy_end: assert property ($fell(conv_active) |-> ##[0:2] drdy) else $error("no drdy");
    chk_conv_len: assert property ($fell(conv_active) |->
        run_q inside {[CONV_CLK-2:CONV_CLK+2], [2*CONV_CLK-2:2*CONV_CLK+2]})
        else $error("conversion length wrong");
endmodule
`default_nettype wire

/* verif/adc_scan_sequencer_tb_top.sv */
// bench: host and device ends joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module adc_scan_sequencer_tb_top;
    import adcss_pkg::*;
    logic        clk, rst, pready, pslverr, conv_active, err;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, mux_code;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] conv_sample = 16'hABCD; // stand-in filter output
    logic [1:0]  gain_sel;
    int          error_cnt = 0, n_compared = 0;
    adcss_link_if link ();
    adcss_host u_adcss_host (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    // longer conversion so every result can be read before it is overwritten
    adcss_dev #(.MCLK_DIV(8'h02), .CONV_MCLK(23'h000200)) u_adcss_dev (.clk(clk), .rst(rst),
        .link(link), .conv_sample(conv_sample), .mux_code(mux_code), .gain_sel(gain_sel),
        .conv_active(conv_active));
    adcss_sva #(.CONV_CLK(1024)) u_adcss_sva (.clk(clk), .rst(rst), .sck(link.sck),
        .cs_n(link.cs_n), .drdy(link.drdy), .mux_code(mux_code), .gain_sel(gain_sel),
        .conv_active(conv_active));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            error_cnt++;
            final_report();
        end
    endtask
    // one apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        bound(n, 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one device frame, waits until the host is idle, leaves read data in rd
    task automatic dev(input logic r, input logic [3:0] a, input logic [23:0] d);
        int n;
        apb(1'b1, HOST_CMD, {r, 3'h0, a, d});
        n = 0;
        do begin
            apb(1'b0, HOST_STAT, 32'h0);
            n++;
        end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 400);
        bound(n, 400);
        apb(1'b0, HOST_RDATA, 32'h0);
    endtask
    // polls status until data ready shows
    task automatic wait_drdy();
        int n;
        n = 0;
        do begin
            apb(1'b0, HOST_STAT, 32'h0);
            n++;
        end while (rd[STAT_DRDY_BIT] !== 1'b1 && n < 1000);
        bound(n, 1000);
    endtask
    // waits for data ready, then checks the tagged result
    task automatic result(input logic [3:0] tag);
        wait_drdy();
        dev(1'b1, ADDR_RESULT, 24'h0);
        check(rd[23:0], {tag, 4'h0, 16'hABCD});
    endtask
    task automatic t_reset();
        dev(1'b1, ADDR_INSEL, 24'h0);
        check(rd[23:0], {16'h0, INSEL_RST});
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        dev(1'b0, ADDR_OFSCAL, 24'hFFF000); // negated offset written back
        dev(1'b1, ADDR_OFSCAL, 24'h0);
        check(rd[23:0], 24'hFFF000);
        $display("test reset done");
    endtask
    task automatic t_oneshot();
        logic [11:0] tl;
        tl = 12'hDC0; // supply, temperature, input 0, in priority order
        dev(1'b0, ADDR_INSEL, 24'h000023); // ignored while scanning
        dev(1'b0, ADDR_MODE, 24'h00000C);
        dev(1'b0, ADDR_SCAN, 24'h103001);
        dev(1'b0, ADDR_CONFIG, 24'h000003);
        for (int i = 0; i < 3; i++) result(tl[11-4*i -: 4]);
        dev(1'b1, ADDR_CONFIG, 24'h0);
        check(rd[1:0], STATE_OFF);
        $display("test one-shot scan done");
    endtask
    task automatic t_repeat();
        dev(1'b0, ADDR_MODE, 24'h00000F);
        dev(1'b0, ADDR_TIMER, 24'h000004);
        dev(1'b0, ADDR_SCAN, 24'h004000);
        dev(1'b0, ADDR_CONFIG, 24'h000003);
        result(4'hE);
        wait_drdy();
        dev(1'b0, ADDR_MODE, 24'h00000C);
        dev(1'b1, ADDR_CONFIG, 24'h0);
        check(rd[1:0], STATE_RUN);
        repeat (2) result(4'hE);
        dev(1'b1, ADDR_CONFIG, 24'h0);
        check(rd[1:0], STATE_OFF);
        $display("test repeating scan done");
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_oneshot();
        t_repeat();
        final_report();
    end
endmodule
`default_nettype wire
